// file: esp_pkg.sv
// Constants for the enhanced serial port: register map, fields, reset values, timing
package esp_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_BUF = 8'h99;
  localparam logic [7:0] ADDR_ID = 8'ha9;
  localparam logic [7:0] ADDR_MASK = 8'hb9;
  // Fields of serial_control
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MP = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Oscillator clocks per mode 0 bit
  localparam logic [3:0] M0_DIV_SLOW = 4'hc;
  localparam logic [3:0] M0_DIV_FAST = 4'h4;
  // Mode 2 sample tick: 64 clocks per bit over 16 ticks is 4, doubled is 2
  localparam logic [1:0] M2_TICK_DIV = 2'h3;
  localparam logic [1:0] M2_TICK_DIV_DBL = 2'h1;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_SAMPLE = 4'h8;
  localparam logic [3:0] BITS_M0 = 4'h8;
  localparam logic [3:0] BITS_FRAME10 = 4'ha;
  localparam logic [3:0] BITS_FRAME11 = 4'hb;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC = 2'b11
  } esp_tx_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } esp_rx_type;
endpackage

// file: esp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module esp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// file: esp_serial_port.sv
// Enhanced serial port: register access, bit timing, transmitter and receiver
`timescale 1ns/100ps
// What this block does
// R1: Control bit 7 is high mode bit or framing flag, per frame_err_select.
// R2: Framing flag sets on a bad stop bit, stays set until software clears.
// R3: Mode 0 is synchronous 8-bit shifting at 4 or 12 clocks per bit.
// R4: Mode 2 is asynchronous with 64 or 32 clocks per bit.
// R5: Mode 3 is asynchronous 11-bit frames timed by timer overflow.
// R6: Modes 2 and 3 with filter on: no receive flag if ninth bit is 0.
// R7: Mode 1 with filter on: no receive flag without a valid stop bit.
// R8: In mode 0 the filter bit picks the shift clock; 0 means divide by 12.
// R9: Receive only while receive-allow is set; otherwise ignore the line.
// R10: Modes 2 and 3 send the software ninth bit as ninth data bit.
// R11: Received ninth bit holds ninth bit, or stop bit in mode 1 unfiltered.
// R12: Transmit flag sets after bit 8 in mode 0, at stop start otherwise.
// R13: Receive flag sets after bit 8 in mode 0, mid stop otherwise, filtered.
// R14: Buffer address reads receive register, write loads transmit and starts.
// R15: Software programs own_node_id with the address this node answers.
// R16: Address match compares only bit positions whose mask bit is 1.
// R17: An all-zero mask accepts any address and raises the receive flag.
// R18: Interrupt reaches the processor only with serial and global enables set.
// R19: baud_double doubles the bit rate in modes 1, 2 and 3.
// R20: frame_err_select 0 gives plain mode bit, 1 gives framing flag.
// R21: Modes 1 and 3 pick timer 1 or timer 2 overflow per direction.
// R22: Filtered address frames raise the receive flag only on masked match.
// R23: Both ends share mode and rate; receiver samples bit centres.
module esp_serial_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic tx_buf_ready,
  input wire logic baud_double,
  input wire logic frame_err_select,
  input wire logic serial_irq_on,
  input wire logic global_irq_on,
  input wire logic rx_clk_sel,
  input wire logic tx_clk_sel,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic serial_irq
);
  logic [7:0] ctrl_ff;
  logic mode_hi_ff;
  logic frame_err_ff;
  logic [7:0] rx_buf_ff;
  logic [7:0] own_node_id_ff;
  logic [7:0] node_match_mask_ff;
  logic [7:0] rdata_ff;
  logic rxd_meta_ff;
  logic rxd_sync_ff;
  logic [1:0] m2_div_ff;
  logic tx_half_ff;
  logic rx_half_ff;
  esp_pkg::esp_tx_type tx_state_ff;
  logic tx_dir_out_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_tick_ff;
  logic [3:0] tx_bits_ff;
  logic [3:0] m0_cnt_ff;
  esp_pkg::esp_rx_type rx_state_ff;
  logic [3:0] rx_tick_ff;
  logic [3:0] rx_bits_ff;
  logic [8:0] rx_sh_ff;
  logic rx_armed_ff;

  // Register decode
  wire wr_ctrl = sfr_wr && (sfr_addr == esp_pkg::ADDR_CTRL);
  wire wr_buf = sfr_wr && (sfr_addr == esp_pkg::ADDR_BUF);
  wire wr_id = sfr_wr && (sfr_addr == esp_pkg::ADDR_ID);
  wire wr_mask = sfr_wr && (sfr_addr == esp_pkg::ADDR_MASK);
  wire [1:0] mode = {mode_hi_ff, ctrl_ff[esp_pkg::BIT_MODE_LO]};
  wire mp_on = ctrl_ff[esp_pkg::BIT_MP];
  wire ren = ctrl_ff[esp_pkg::BIT_REN];
  wire ri = ctrl_ff[esp_pkg::BIT_RI];
  wire ctrl_top = frame_err_select ? frame_err_ff : mode_hi_ff; // see R1 see R20
  wire [7:0] ctrl_view = {ctrl_top, ctrl_ff[6:0]};
  wire [7:0] rd_mux = (sfr_addr == esp_pkg::ADDR_CTRL) ? ctrl_view :
                      (sfr_addr == esp_pkg::ADDR_BUF) ? rx_buf_ff :
                      (sfr_addr == esp_pkg::ADDR_ID) ? own_node_id_ff :
                      (sfr_addr == esp_pkg::ADDR_MASK) ? node_match_mask_ff : 8'h00;
  assign sfr_rdata = rdata_ff;

  // Transmit buffer: a write to the buffer address is queued here
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire tx_load;
  esp_fifo #(
    .WIDTH(esp_pkg::FIFO_WIDTH),
    .DEPTH(esp_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr_buf), // see R14
    .in_ready(tx_buf_ready),
    .in_data(sfr_wdata),
    .out_valid(fifo_valid),
    .out_ready(tx_load),
    .out_data(fifo_data)
  );

  // Bit timing: 16 sample ticks per bit in modes 1 to 3
  wire [1:0] m2_last = baud_double ? esp_pkg::M2_TICK_DIV_DBL : esp_pkg::M2_TICK_DIV; // see R19
  wire m2_tick = (m2_div_ff == m2_last); // see R4
  wire tx_ovf = tx_clk_sel ? timer2_ovf : timer1_ovf; // see R21
  wire rx_ovf = rx_clk_sel ? timer2_ovf : timer1_ovf; // see R21
  // Without doubling only every second overflow counts, giving ovf/32 per bit
  wire tx_tick = (mode == 2'd2) ? m2_tick : (tx_ovf && (baud_double || tx_half_ff)); // see R5
  wire rx_tick = (mode == 2'd2) ? m2_tick : (rx_ovf && (baud_double || rx_half_ff));
  wire [3:0] m0_div = mp_on ? esp_pkg::M0_DIV_FAST : esp_pkg::M0_DIV_SLOW; // see R8 see R3
  wire m0_end = (m0_cnt_ff == m0_div - 4'h1);
  wire m0_clk_low = (m0_cnt_ff < {1'b0, m0_div[3:1]});

  // Transmitter and mode 0 shift engine
  wire tx_idle = (tx_state_ff == esp_pkg::TX_IDLE);
  wire m0_rx_start = tx_idle && (mode == 2'd0) && ren && !ri && !fifo_valid; // see R9
  assign tx_load = tx_idle && fifo_valid;
  wire [3:0] frame_bits = mode[1] ? esp_pkg::BITS_FRAME11 : esp_pkg::BITS_FRAME10;
  wire tx_ninth = mode[1] ? ctrl_ff[esp_pkg::BIT_TB8] : 1'b1; // see R10
  wire tx_bit_end = (tx_state_ff == esp_pkg::TX_ASYNC) && tx_tick &&
                    (tx_tick_ff == esp_pkg::TICK_LAST);
  wire m0_bit_end = (tx_state_ff == esp_pkg::TX_SYNC) && m0_end;
  // Stop bit begins when only it is left to send
  wire ti_async = tx_bit_end && (tx_bits_ff == 4'h2); // see R12
  wire m0_last = m0_bit_end && (tx_bits_ff == 4'h1);
  wire ti_set = ti_async || (m0_last && tx_dir_out_ff); // see R12
  wire m0_rx_done = m0_last && !tx_dir_out_ff; // see R13

  // Asynchronous receiver
  wire rx_sample = rx_tick && (rx_tick_ff == esp_pkg::TICK_SAMPLE); // see R23
  wire rx_nine = mode[1];
  wire [7:0] rx_byte = rx_nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
  wire rx_ninth = rx_sh_ff[8];
  wire stop_ok = rxd_sync_ff;
  wire stop_sample = (rx_state_ff == esp_pkg::RX_STOP) && rx_sample;
  wire addr_match = (((rx_byte ^ own_node_id_ff) & node_match_mask_ff) == 8'h00); // see R16 see R17
  wire accept_m1 = !mp_on || stop_ok; // see R7
  wire accept_m23 = !mp_on || (rx_ninth && addr_match); // see R6 see R22
  wire rx_accept = stop_sample && !ri && (rx_nine ? accept_m23 : accept_m1); // see R13
  wire rb8_value = rx_nine ? rx_ninth : stop_ok; // see R11
  wire rb8_load = rx_accept && (rx_nine || !mp_on);
  wire fe_set = stop_sample && !stop_ok; // see R2
  wire ri_set = rx_accept || m0_rx_done;

  // Flags: a hardware set in the same cycle as a software write wins
  wire [7:0] ctrl_wr = wr_ctrl ? sfr_wdata : ctrl_ff;
  wire nxt_ti = ctrl_wr[esp_pkg::BIT_TI] | ti_set; // see R12
  wire nxt_ri = ctrl_wr[esp_pkg::BIT_RI] | ri_set; // see R13
  wire nxt_rb8 = rb8_load ? rb8_value : ctrl_wr[esp_pkg::BIT_RB8];
  wire nxt_fe = ((wr_ctrl && frame_err_select) ? sfr_wdata[7] : frame_err_ff) | fe_set; // see R2

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_ff <= esp_pkg::RST_CTRL;
      mode_hi_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      own_node_id_ff <= esp_pkg::RST_BYTE;
      node_match_mask_ff <= esp_pkg::RST_BYTE;
      rdata_ff <= esp_pkg::RST_BYTE;
    end else begin
      ctrl_ff <= {1'b0, ctrl_wr[6:3], nxt_rb8, nxt_ti, nxt_ri};
      frame_err_ff <= nxt_fe;
      if (wr_ctrl && !frame_err_select) begin
        mode_hi_ff <= sfr_wdata[7]; // see R20
      end
      if (wr_id) begin
        own_node_id_ff <= sfr_wdata; // see R15
      end
      if (wr_mask) begin
        node_match_mask_ff <= sfr_wdata;
      end
      if (sfr_rd) begin
        rdata_ff <= rd_mux; // see R14
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_buf_ff <= esp_pkg::RST_BYTE;
    end else if (rx_accept) begin
      rx_buf_ff <= rx_byte;
    end else if (m0_rx_done) begin
      rx_buf_ff <= {rxd_sync_ff, tx_sh_ff[7:1]};
    end
  end

  // Line input crosses into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
    end else begin
      rxd_meta_ff <= rxd_in;
      rxd_sync_ff <= rxd_meta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      m2_div_ff <= 2'h0;
      tx_half_ff <= 1'b0;
      rx_half_ff <= 1'b0;
    end else begin
      m2_div_ff <= m2_tick ? 2'h0 : m2_div_ff + 2'h1;
      if (tx_ovf) begin
        tx_half_ff <= !tx_half_ff;
      end
      if (rx_ovf) begin
        rx_half_ff <= !rx_half_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state_ff <= esp_pkg::TX_IDLE;
      tx_dir_out_ff <= 1'b0;
      tx_sh_ff <= 11'h7ff;
      tx_tick_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
      m0_cnt_ff <= 4'h0;
    end else begin
      case (tx_state_ff)
        esp_pkg::TX_IDLE: begin
          tx_tick_ff <= 4'h0;
          m0_cnt_ff <= 4'h0;
          if (tx_load && mode == 2'd0) begin
            tx_state_ff <= esp_pkg::TX_SYNC; // see R3
            tx_dir_out_ff <= 1'b1;
            tx_sh_ff <= {3'h7, fifo_data};
            tx_bits_ff <= esp_pkg::BITS_M0;
          end else if (tx_load) begin
            tx_state_ff <= esp_pkg::TX_ASYNC;
            tx_sh_ff <= mode[1] ? {1'b1, tx_ninth, fifo_data, 1'b0}
                                : {2'h3, fifo_data, 1'b0};
            tx_bits_ff <= frame_bits;
          end else if (m0_rx_start) begin
            tx_state_ff <= esp_pkg::TX_SYNC;
            tx_dir_out_ff <= 1'b0;
            tx_bits_ff <= esp_pkg::BITS_M0;
          end
        end
        esp_pkg::TX_ASYNC: begin
          if (tx_tick) begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
          end
          if (tx_bit_end) begin
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_bits_ff <= tx_bits_ff - 4'h1;
            if (tx_bits_ff == 4'h1) begin
              tx_state_ff <= esp_pkg::TX_IDLE;
            end
          end
        end
        esp_pkg::TX_SYNC: begin
          m0_cnt_ff <= m0_end ? 4'h0 : m0_cnt_ff + 4'h1;
          // Mode 0 receive samples the data pin at the end of each bit, clock high
          if (m0_bit_end) begin
            tx_sh_ff <= tx_dir_out_ff ? {1'b1, tx_sh_ff[10:1]}
                                      : {3'h7, rxd_sync_ff, tx_sh_ff[7:1]};
            tx_bits_ff <= tx_bits_ff - 4'h1;
            if (tx_bits_ff == 4'h1) begin
              tx_state_ff <= esp_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_ff <= esp_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Receiver only runs in modes 1 to 3; a new start is not taken while disabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_state_ff <= esp_pkg::RX_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bits_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
      rx_armed_ff <= 1'b0;
    end else begin
      if (rx_tick) begin
        rx_tick_ff <= rx_tick_ff + 4'h1;
      end
      // Line must be seen idle first, so the tail of a low stop bit is no new start
      rx_armed_ff <= (rx_state_ff == esp_pkg::RX_IDLE) && (rx_armed_ff || rxd_sync_ff);
      case (rx_state_ff)
        esp_pkg::RX_IDLE: begin
          if (rx_tick && ren && mode != 2'd0 && !rxd_sync_ff && rx_armed_ff) begin // see R9
            rx_state_ff <= esp_pkg::RX_START;
            rx_tick_ff <= 4'h1;
          end
        end
        esp_pkg::RX_START: begin
          // A start bit that is high again at its centre was a glitch
          if (rx_sample) begin
            rx_state_ff <= rxd_sync_ff ? esp_pkg::RX_IDLE : esp_pkg::RX_DATA;
            rx_bits_ff <= rx_nine ? 4'h9 : 4'h8;
          end
        end
        esp_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_sh_ff <= {rxd_sync_ff, rx_sh_ff[8:1]};
            rx_bits_ff <= rx_bits_ff - 4'h1;
            if (rx_bits_ff == 4'h1) begin
              rx_state_ff <= esp_pkg::RX_STOP;
            end
          end
        end
        esp_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_ff <= esp_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_ff <= esp_pkg::RX_IDLE;
        end
      endcase
    end
  end

  wire m0_active = (tx_state_ff == esp_pkg::TX_SYNC);
  assign txd_out = m0_active ? !m0_clk_low : tx_sh_ff[0];
  assign rxd_oe = m0_active && tx_dir_out_ff;
  assign rxd_out = rxd_oe ? tx_sh_ff[0] : 1'b1;
  assign serial_irq = (ctrl_ff[esp_pkg::BIT_TI] | ri) & serial_irq_on & global_irq_on; // see R18
endmodule

// file: esp_monitor.sv
// Checker for register access and pin idle behaviour of the serial port
`timescale 1ns/100ps
module esp_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic tx_buf_ready,
  input wire logic serial_irq_on,
  input wire logic global_irq_on,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic serial_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] id_ff;
  logic [7:0] mask_ff;
  wire id_sel = sfr_addr == esp_pkg::ADDR_ID;
  wire mask_sel = sfr_addr == esp_pkg::ADDR_MASK;
  wire ctl_sel = sfr_addr == esp_pkg::ADDR_CTRL || sfr_addr == esp_pkg::ADDR_BUF;
  wire mapped = ctl_sel || id_sel || mask_sel;
  // Shadow copies let a readback be judged against the last write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      id_ff <= esp_pkg::RST_BYTE;
      mask_ff <= esp_pkg::RST_BYTE;
    end else begin
      if (sfr_wr && id_sel) id_ff <= sfr_wdata;
      if (sfr_wr && mask_sel) mask_ff <= sfr_wdata;
    end
  end
  irq_gate_a: assert property (serial_irq |-> serial_irq_on && global_irq_on)
    else $error("interrupt raised without both enables");
  idle_drive_a: assert property (!rxd_oe |-> rxd_out)
    else $error("data pin low while not driven");
  shift_clk_start_a: assert property ($rose(rxd_oe) |-> !txd_out)
    else $error("shift clock not low at start of shifting");
  buf_full_a: assert property ($fell(tx_buf_ready) |->
    $past(sfr_wr) && $past(sfr_addr) == esp_pkg::ADDR_BUF)
    else $error("transmit buffer filled without a write");
  rdata_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  id_readback_a: assert property (sfr_rd && !sfr_wr && id_sel |=> sfr_rdata == id_ff)
    else $error("node id readback wrong");
  mask_readback_a: assert property (sfr_rd && !sfr_wr && mask_sel |=> sfr_rdata == mask_ff)
    else $error("node mask readback wrong");
  reset_idle_a: assert property ($rose(resetn) |->
    txd_out && !rxd_oe && !serial_irq && tx_buf_ready && sfr_rdata == 8'h00)
    else $error("outputs not idle after reset");
endmodule
bind esp_serial_port esp_monitor mon_u (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .tx_buf_ready(tx_buf_ready), .serial_irq_on(serial_irq_on), .global_irq_on(global_irq_on),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .serial_irq(serial_irq));

// file: esp_far_node.sv
// Far serial node: frame sender and centre-sampling frame receiver
`timescale 1ns/100ps
module esp_far_node (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_cyc = 64;
  int nbits = 9;
  logic listen = 1'b0;
  logic [8:0] got_word = 9'h000;
  logic got_stop = 1'b0;
  int got_cnt = 0;
  initial line_out = 1'b1;
  // Same frame and rate as the port, sampled at bit centres
  always @(posedge clk) begin
    if (listen && !line_in) begin
      got_word = 9'h000;
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clk);
        got_word[i] = line_in;
      end
      repeat (bit_cyc) @(posedge clk);
      got_stop = line_in;
      got_cnt++;
    end
  end
  // Called just after a clock edge; line returns to idle high after each frame
  task automatic send(input logic [8:0] w, input int nb, input logic stop);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= w[i];
      repeat (bit_cyc) @(posedge clk);
    end
    line_out <= stop;
    repeat (bit_cyc) @(posedge clk);
    line_out <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the enhanced serial port
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam logic [7:0] A_CTRL = esp_pkg::ADDR_CTRL;
  localparam logic [7:0] A_BUF = esp_pkg::ADDR_BUF;
  logic clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
  logic baud_double = 1'b0, frame_err_select = 1'b0, rx_clk_sel = 1'b0, tx_clk_sel = 1'b0;
  logic serial_irq_on = 1'b1, global_irq_on = 1'b1, timer1_ovf = 1'b0, timer2_ovf = 1'b0;
  logic tx_buf_ready, rxd_in, rxd_out, rxd_oe, txd_out, serial_irq, txd_q, wr_ok;
  int n_errors = 0, cmp_count = 0, t1c = 0, t2c = 0;
  logic [9:0] ftab [4] = '{10'h35f, 10'h14a, 10'h05a, 10'h312};
  logic [23:0] mtab [4] = '{24'h50ffd1, 24'h50ff55, 24'h70fbf0, 24'h70fb71};
  esp_serial_port dut_u (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_buf_ready(tx_buf_ready),
    .baud_double(baud_double), .frame_err_select(frame_err_select),
    .serial_irq_on(serial_irq_on), .global_irq_on(global_irq_on), .rx_clk_sel(rx_clk_sel),
    .tx_clk_sel(tx_clk_sel), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .serial_irq(serial_irq));
  esp_far_node far_u (.clk(clk), .line_in(txd_out), .line_out(rxd_in));
  initial begin
    forever #50 clk = ~clk;
  end
  // Two timers with unlike periods, so a swapped source shows as a rate error
  always @(posedge clk) begin
    t1c <= (t1c == 2) ? 0 : t1c + 1;
    t2c <= (t2c == 4) ? 0 : t2c + 1;
    timer1_ovf <= (t1c == 2);
    timer2_ovf <= (t2c == 4);
    txd_q <= txd_out;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    wr_ok = tx_buf_ready;
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    rv = sfr_rdata;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    rd(a);
    `CHK(nm, ex, rv)
  endtask
  task automatic wait_frames(input int n);
    for (int c = 0; c < 4000 && far_u.got_cnt < n; c++) @(posedge clk);
    `CHK("frame count", n, far_u.got_cnt)
  endtask
  task automatic m0_rx(input int div);
    int n;
    int gap;
    logic [7:0] d;
    n = 0;
    gap = 0;
    d = 8'h00;
    for (int c = 0; c < 300 && n < 8; c++) begin
      @(posedge clk);
      gap++;
      if (txd_out && !txd_q) begin
        if (n > 0) `CHK("shift period", div, gap)
        `CHK("shift drive", 1'b1, rxd_oe)
        d[n] = rxd_out;
        n++;
        gap = 0;
      end
    end
    `CHK("shift data", 8'h96, d)
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(50000 * 100);
    $display("ERROR watchdog expected finish seen hang");
    n_errors++;
    end_of_test;
  end
  initial begin
    int n;
    int acc;
    logic [7:0] lastq;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("ctrl reset", A_CTRL, esp_pkg::RST_CTRL);
    rd_chk("mask reset", esp_pkg::ADDR_MASK, esp_pkg::RST_BYTE);
    rd_chk("unmapped", 8'h9a, 8'h00);
    wr(esp_pkg::ADDR_ID, 8'h5a);
    wr(esp_pkg::ADDR_MASK, 8'hf0);
    rd_chk("node id", esp_pkg::ADDR_ID, 8'h5a);
    wr(A_CTRL, 8'hc0);
    rd_chk("mode bits", A_CTRL, 8'hc0);
    $display("test registers done");
    far_u.listen = 1'b1;
    for (int k = 0; k < 2; k++) begin
      baud_double <= k[0];
      far_u.bit_cyc = k ? 32 : 64;
      wr(A_CTRL, k ? 8'h80 : 8'h88);
      n = far_u.got_cnt + 1;
      wr(A_BUF, k ? 8'h3c : 8'ha5);
      wait_frames(n);
      `CHK("tx word", {~k[0], k ? 8'h3c : 8'ha5}, far_u.got_word)
      `CHK("tx stop", 1'b1, far_u.got_stop)
      rd_chk("tx done", A_CTRL, k ? 8'h82 : 8'h8a);
      `CHK("irq on", 1'b1, serial_irq)
    end
    global_irq_on <= 1'b0;
    @(posedge clk);
    `CHK("irq gated", 1'b0, serial_irq)
    global_irq_on <= 1'b1;
    acc = 0;
    n = far_u.got_cnt;
    for (int k = 0; k < 6; k++) begin
      wr(A_BUF, 8'h10 + k[7:0]);
      acc += int'(wr_ok);
      if (wr_ok) lastq = 8'h10 + k[7:0];
    end
    `CHK("buffer refused", 1'b1, acc < 6)
    wait_frames(n + acc);
    repeat (400) @(posedge clk);
    `CHK("queued frames", n + acc, far_u.got_cnt)
    `CHK("last queued", {1'b0, lastq}, far_u.got_word)
    $display("test transmit done");
    wr(A_CTRL, 8'h90);
    @(posedge clk);
    far_u.send(9'h13c, 9, 1'b1);
    rd_chk("rx byte", A_BUF, 8'h3c);
    rd_chk("rx flags", A_CTRL, 8'h95);
    wr(A_CTRL, 8'h80);
    @(posedge clk);
    far_u.send(9'h1c3, 9, 1'b1);
    rd_chk("rx disabled", A_CTRL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) wr(esp_pkg::ADDR_MASK, 8'h00);
      wr(A_CTRL, 8'hb0);
      @(posedge clk);
      far_u.send(ftab[k][8:0], 9, 1'b1);
      rd(A_CTRL);
      `CHK("filtered flag", ftab[k][9], rv[esp_pkg::BIT_RI])
    end
    $display("test receive done");
    wr(A_CTRL, 8'h50);
    frame_err_select <= 1'b1;
    rx_clk_sel <= 1'b1;
    far_u.bit_cyc = 80;
    far_u.nbits = 8;
    for (int k = 0; k < 4; k++) begin
      wr(A_CTRL, mtab[k][23:16]);
      @(posedge clk);
      far_u.send(9'h081, 8, k[0]);
      rd(A_CTRL);
      `CHK("frame flags", mtab[k][7:0], rv & mtab[k][15:8])
    end
    frame_err_select <= 1'b0;
    far_u.bit_cyc = 48;
    for (int k = 0; k < 2; k++) begin
      far_u.nbits = 8 + k;
      wr(A_CTRL, k ? 8'hc8 : 8'h40);
      n = far_u.got_cnt + 1;
      wr(A_BUF, 8'h6e + k[7:0]);
      wait_frames(n);
      `CHK("timed tx", {k[0], 8'h6e + k[7:0]}, far_u.got_word)
    end
    $display("test timed modes done");
    far_u.listen = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(A_CTRL, k ? 8'h20 : 8'h00);
      wr(A_BUF, 8'h96);
      m0_rx(k ? 4 : 12);
      repeat (12) @(posedge clk);
      rd_chk("shift done", A_CTRL, k ? 8'h22 : 8'h02);
    end
    far_u.line_out <= 1'b0;
    wr(A_CTRL, 8'h10);
    repeat (120) @(posedge clk);
    rd_chk("shift rx flag", A_CTRL, 8'h11);
    rd_chk("shift rx byte", A_BUF, 8'h00);
    $display("test shift mode done");
    end_of_test;
  end
endmodule
